// File: rtl/psr_decoder.sv
/*
 * Pump status decoder: maps start, rotor, speed and error conditions onto the
 * drive enable, two relays and two lamps, with a classic Wishbone register slave.
 * Assumes condition inputs are levels from the converter, synchronised here.
 */
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "psr_params.svh"
module psr_decoder
    import psr_pkg::*;
#(
    parameter int TICK_CYCLES = `PSR_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Condition inputs.
    input wire logic start_cmd,
    input wire logic rotor_turning,
    input wire logic at_speed,
    input wire logic error_present,
    // Drive, relays and lamps.
    output logic motor_drive,
    output logic run_relay,
    output logic fault_relay,
    output logic status_lamp,
    output logic fault_lamp,
    // Interrupt.
    output logic irq
);
    psr_flash_if fl ();

    psr_cond_t s1_r;
    psr_cond_t in_r;
    psr_cond_t prev_r;
    psr_mode_t mode_r;
    psr_mode_t mode_nxt;
    logic [15:0] ctrl_r;
    logic [`PSR_EV_W-1:0] mask_r;
    logic [`PSR_EV_W-1:0] event_r;
    logic [`PSR_EV_W-1:0] ev;
    logic [`PSR_EV_W-1:0] clr;
    logic fail_now;
    logic req;
    logic normal;

    psr_flasher #(.TICK_CYCLES(TICK_CYCLES)) u_flasher (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .fl(fl)
    );
    assign fl.half_ms = ctrl_r;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr[7:2] == off[7:2]);
    endfunction : hit

    // Two stages; only the second stage is decoded.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_r <= '0;
            in_r <= '0;
        end else begin
            s1_r <= {start_cmd, rotor_turning, at_speed, error_present};
            in_r <= s1_r;
        end
    end

    assign normal = in_r.start && in_r.rot && in_r.spd && !in_r.err;
    // At speed without rotation is not a tabulated state.
    assign fail_now = in_r.spd && !in_r.rot;

    always_comb begin
        mode_nxt = PSR_STOPPED;
        if (in_r.err) begin
            mode_nxt = PSR_FAULT;
        end else if (normal) begin
            mode_nxt = PSR_NORMAL;
        end else if (in_r.start) begin
            mode_nxt = PSR_SPINUP;
        end else if (in_r.rot) begin
            mode_nxt = PSR_RUNDOWN;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_r <= PSR_STOPPED;
            prev_r <= '0;
        end else begin
            mode_r <= mode_nxt;
            prev_r <= in_r;
        end
    end

    // Outputs follow the synchronised conditions one cycle later.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            motor_drive <= 1'b0;
            run_relay <= 1'b0;
            fault_relay <= 1'b0;
            fault_lamp <= 1'b0;
            status_lamp <= 1'b0;
        end else begin
            motor_drive <= in_r.start && !in_r.err;
            run_relay <= normal;
            fault_relay <= in_r.err;
            fault_lamp <= in_r.err;
            if (!in_r.rot) begin
                status_lamp <= 1'b0;
            end else if (normal) begin
                status_lamp <= 1'b1;
            end else begin
                status_lamp <= fl.phase;
            end
        end
    end

    always_comb begin
        ev = '0;
        ev[`PSR_EV_ERR_RISE] = in_r.err && !prev_r.err;
        ev[`PSR_EV_RUN_ENTER] = (mode_nxt == PSR_NORMAL) && (mode_r != PSR_NORMAL);
        ev[`PSR_EV_RUN_LEAVE] = (mode_nxt != PSR_NORMAL) && (mode_r == PSR_NORMAL);
        ev[`PSR_EV_INT_FAIL] = fail_now;
        ev[`PSR_EV_STANDSTILL] = !in_r.rot && prev_r.rot;
    end

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign clr = (req && !wb_we_i && hit(wb_adr_i, `PSR_OFF_EVENT)) ? event_r : '0;

    // A new event in the clearing cycle survives the read.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            event_r <= '0;
        end else begin
            event_r <= (event_r & ~clr) | ev;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= `PSR_CTRL_RST;
            mask_r <= `PSR_MASK_RST;
        end else if (req && wb_we_i) begin
            if (hit(wb_adr_i, `PSR_OFF_CTRL)) begin
                if (wb_sel_i[0]) begin
                    ctrl_r[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    ctrl_r[15:8] <= wb_dat_i[15:8];
                end
            end
            if (hit(wb_adr_i, `PSR_OFF_MASK) && wb_sel_i[0]) begin
                mask_r <= wb_dat_i[`PSR_EV_W-1:0];
            end
        end
    end

    // Every access is answered after one wait state; unmapped reads give zero.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= 32'h00000000;
            if (req && !wb_we_i) begin
                if (hit(wb_adr_i, `PSR_OFF_CTRL)) begin
                    wb_dat_o <= {16'h0000, ctrl_r};
                end else if (hit(wb_adr_i, `PSR_OFF_STATE)) begin
                    wb_dat_o <= {23'h000000, mode_r, in_r};
                end else if (hit(wb_adr_i, `PSR_OFF_EVENT)) begin
                    wb_dat_o <= {27'h0000000, event_r};
                end else if (hit(wb_adr_i, `PSR_OFF_MASK)) begin
                    wb_dat_o <= {27'h0000000, mask_r};
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= |((event_r & ~clr | ev) & mask_r);
        end
    end

    AST_RUN_RELAY: assert property (@(posedge ref_clk) disable iff (!rst_b)
        run_relay == ($past(in_r.start) && $past(in_r.rot) && $past(in_r.spd)
            && !$past(in_r.err)))
        else $error("run relay does not match started at-speed error-free state");

    AST_FAULT_PAIR: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $past(in_r.err) |-> fault_relay && fault_lamp)
        else $error("fault relay or lamp idle while error present");

    AST_DRIVE_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (in_r.err || !in_r.start) |=> !motor_drive)
        else $error("drive enabled during stop or error");

    AST_LAMP_STILL: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !in_r.rot |=> !status_lamp)
        else $error("status lamp lit at standstill");

    AST_ERR_AT_SPEED: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (run_relay && in_r.err) |=> !run_relay && fault_relay)
        else $error("error at speed did not drop run relay");

    AST_FAIL_FLAG: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (in_r.spd && !in_r.rot) |=> event_r[`PSR_EV_INT_FAIL])
        else $error("internal failure not flagged");

    AST_SYNC_PATH: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $past(rst_b, 2) |-> in_r.start == $past(start_cmd, 2)
            && in_r.rot == $past(rotor_turning, 2) && in_r.spd == $past(at_speed, 2)
            && in_r.err == $past(error_present, 2))
        else $error("synchroniser output is not the input two edges back");

    AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : psr_decoder

// File: rtl/psr_flash_if.sv
/*
 * Carrier between the decoder and its flash timebase.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface psr_flash_if;
    logic [15:0] half_ms;
    logic phase;
    modport ctl (output half_ms, input phase);
    modport gen (input half_ms, output phase);
endinterface : psr_flash_if

// File: rtl/psr_flasher.sv
/*
 * Slow flash timebase: a millisecond prescaler and a half-period counter.
 * Assumes the half period arrives through the flash carrier in milliseconds.
 */
`timescale 1ns/1ps
`include "psr_params.svh"
module psr_flasher
    import psr_pkg::*;
#(
    parameter int TICK_CYCLES = `PSR_TICK_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic rst_b,
    // Flash carrier.
    psr_flash_if.gen fl
);
    logic [23:0] pre_r;
    logic [15:0] ms_r;
    logic tick;
    logic phase_r;

    assign tick = (pre_r == 24'(TICK_CYCLES - 1));

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_r <= 24'h000000;
        end else if (tick) begin
            pre_r <= 24'h000000;
        end else begin
            pre_r <= pre_r + 24'h000001;
        end
    end

    // A zero half period is taken as one, so the lamp never freezes mid-flash.
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ms_r <= 16'h0000;
            phase_r <= 1'b0;
        end else if (tick) begin
            if (ms_r + 16'h0001 >= fl.half_ms) begin
                ms_r <= 16'h0000;
                phase_r <= ~phase_r;
            end else begin
                ms_r <= ms_r + 16'h0001;
            end
        end
    end

    assign fl.phase = phase_r;

endmodule : psr_flasher

// File: rtl/psr_params.svh
/*
 * Offsets, field positions, reset values and timing figures of the pump status decoder.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef PSR_PARAMS_SVH
`define PSR_PARAMS_SVH

// Register byte offsets on the bus.
`define PSR_OFF_CTRL 8'h00
`define PSR_OFF_STATE 8'h04
`define PSR_OFF_EVENT 8'h08
`define PSR_OFF_MASK 8'h0C

// Reset values.
`define PSR_CTRL_RST 16'h00FA
`define PSR_MASK_RST 5'h00

// Event bit positions.
`define PSR_EV_ERR_RISE 0
`define PSR_EV_RUN_ENTER 1
`define PSR_EV_RUN_LEAVE 2
`define PSR_EV_INT_FAIL 3
`define PSR_EV_STANDSTILL 4
`define PSR_EV_W 5

// Timing: flash timebase tick in ns, clock period in ns.
`define PSR_TICK_NS 1000000
`define PSR_CLK_NS 5
`define PSR_TICK_CYCLES (`PSR_TICK_NS / `PSR_CLK_NS)

`endif

// File: rtl/psr_pkg.sv
/*
 * Types shared by the pump status decoder modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package psr_pkg;

    typedef enum logic [4:0] {
        PSR_STOPPED = 5'h01,
        PSR_SPINUP = 5'h02,
        PSR_NORMAL = 5'h04,
        PSR_RUNDOWN = 5'h08,
        PSR_FAULT = 5'h10
    } psr_mode_t;

    typedef struct packed {
        logic start;
        logic rot;
        logic spd;
        logic err;
    } psr_cond_t;

endpackage : psr_pkg

// File: testbench/psr_plant.sv
/*
 * Plant controller model: drives the operator start line, reads relay contacts.
 * Assumes the decoder's clock; contacts are sampled one edge late.
 */
`timescale 1ns/1ps
module psr_plant (
    // Clock.
    input wire logic ref_clk,
    // Operator request and relay contacts.
    input wire logic want_start,
    input wire logic run_relay,
    input wire logic fault_relay,
    // Towards decoder and bench.
    output logic start_cmd,
    output logic [1:0] contacts
);
    always_ff @(posedge ref_clk) begin
        start_cmd <= want_start;
        contacts <= {fault_relay, run_relay};
    end
endmodule : psr_plant

// File: testbench/test_pump_status_relay_decoder.sv
/*
 * Self-checking bench for the pump status decoder: condition table, bus, interrupt.
 * Assumes the design files and the plant model are compiled first.
 */
`timescale 1ns/1ps
`include "psr_params.svh"
module test_pump_status_relay_decoder;
    import psr_pkg::*;
    logic ref_clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q;
    logic [31:0] dat_o;
    logic ack, want = 1'b0, start, rot = 1'b0, spd = 1'b0, err = 1'b0;
    logic [3:0] sel = 4'h0;
    logic drive, run, fault, lamp, flamp, irq;
    logic [1:0] cont;
    int n_mismatch = 0, checks = 0, cyc_cnt = 0;
    always #2.5 ref_clk = ~ref_clk;
    psr_plant i_plant (.ref_clk(ref_clk), .want_start(want), .run_relay(run),
        .fault_relay(fault), .start_cmd(start), .contacts(cont));
    psr_decoder #(.TICK_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rst_b(rst_b),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .start_cmd(start), .rotor_turning(rot), .at_speed(spd),
        .error_present(err), .motor_drive(drive), .run_relay(run),
        .fault_relay(fault), .status_lamp(lamp), .fault_lamp(flamp), .irq(irq));
    task automatic complete_run;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (e !== g) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // One classic cycle; entered right after a rising edge.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        dat <= d;
        do @(posedge ref_clk); while (ack !== 1'b1);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    task automatic cond(input logic [3:0] c);
        {want, rot, spd, err} <= c;
        repeat (6) @(posedge ref_clk);
    endtask : cond
    // Classify the lamp over 40 cycles: 0 dark, 1 flashing, 2 steady.
    task automatic lamp_chk(input logic [1:0] e);
        int n;
        n = 0;
        repeat (40) begin
            @(posedge ref_clk);
            n += (lamp === 1'b1);
        end
        chk("status_lamp", e, (n == 0) ? 0 : (n == 40) ? 2 : 1);
    endtask : lamp_chk
    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        logic s, r, a, e;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        wb(1'b0, `PSR_OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h000000FA, q);
        wb(1'b0, `PSR_OFF_MASK, 32'h0);
        chk("mask reset", 32'h0, q);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped read", 32'h0, q);
        wb(1'b1, `PSR_OFF_CTRL, 32'h00000002);
        wb(1'b0, `PSR_OFF_CTRL, 32'h0);
        chk("ctrl written", 32'h00000002, q);
        $display("register access done");
        for (int i = 0; i < 16; i++) begin
            {s, r, a, e} = i[3:0];
            if (a && !r) continue;
            cond(i[3:0]);
            chk("motor_drive", s & ~e, drive);
            chk("contacts", {e, s & r & a & ~e}, cont);
            chk("fault_lamp", e, flamp);
            chk("irq masked", 1'b0, irq);
            lamp_chk(!r ? 2'd0 : (s & a & ~e) ? 2'd2 : 2'd1);
        end
        $display("condition table done");
        cond(4'h0);
        wb(1'b0, `PSR_OFF_EVENT, 32'h0);
        chk("events after table", 32'h00000017, q);
        wb(1'b1, `PSR_OFF_MASK, 32'h00000001);
        wb(1'b0, `PSR_OFF_MASK, 32'h0);
        chk("mask written", 32'h00000001, q);
        cond(4'h1);
        chk("irq raised", 1'b1, irq);
        wb(1'b0, `PSR_OFF_EVENT, 32'h0);
        chk("error event", 32'h1, q & 32'h1);
        @(posedge ref_clk);
        chk("irq cleared", 1'b0, irq);
        wb(1'b0, `PSR_OFF_STATE, 32'h0);
        chk("state mode and inputs", {23'h000000, PSR_FAULT, 4'h1}, q);
        cond(4'h2);
        wb(1'b0, `PSR_OFF_EVENT, 32'h0);
        chk("failure event", 32'h8, q & 32'h8);
        $display("interrupt and failure done");
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        wb(1'b0, `PSR_OFF_CTRL, 32'h0);
        chk("ctrl after reset", 32'h000000FA, q);
        wb(1'b0, `PSR_OFF_MASK, 32'h0);
        chk("mask after reset", 32'h0, q);
        $display("mid-run reset done");
        complete_run();
    end
endmodule : test_pump_status_relay_decoder
